// ==== cumf_pkg.sv ====
// Contract
// - Feature register absent unless monitors present
// - Feature register is 32-bit read-only
// - Bit 31 shows capture copy support
// - Bit 30 set when counter read-only
// - Bit 29 shows clean exclusion filter
// - Bit 27 shows overflow linkage control
// - Bit 26 shows overflow bitmap register
// - Bit 25 shows overflow on capture
// - Bit 24 shows capture on overflow
// - Bits 15:0 give monitor count
// - Instance fields follow partition instance selector
// - Monitor selection instance never affects reads
// - Separate copy per security space
// - Each page readable; root, realm read-only
// - Same offset in all four pages
// - Main register 64-bit only with extensions
// - Main register absent without partitioning
// - Main bit 32 shows instance selector
// - Main bit 30 shows monitors present
package cumf_pkg;

    // ========================================================================
    // Address map of one feature page
    // ========================================================================
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] FEAT_OFFSET = 12'h088;
    localparam logic [ADDR_W-1:0] MAIN_LO_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] MAIN_HI_OFFSET = 12'h004;

    // ========================================================================
    // Field layout of the usage-monitor feature register
    // ========================================================================
    localparam int CAPTURE_BIT = 31;
    localparam int COUNTER_RO_BIT = 30;
    localparam int CLEAN_EXCL_BIT = 29;
    localparam int LINKAGE_BIT = 27;
    localparam int BITMAP_BIT = 26;
    localparam int OFLOW_ON_CAPT_BIT = 25;
    localparam int CAPT_ON_OFLOW_BIT = 24;
    localparam int COUNT_LSB = 0;
    localparam int COUNT_W = 16;
    localparam logic [31:0] RESERVED_MASK = 32'h10ff_0000;
    localparam logic [31:0] VERSION_MASK = 32'h2f00_0000;

    // ========================================================================
    // Field layout of the main identification register
    // ========================================================================
    localparam int MAIN_MONITORS_BIT = 30;
    localparam int MAIN_EXT_BIT = 28;
    localparam int MAIN_HI_SELECTOR_BIT = 0;

    // ========================================================================
    // Reset values and spaces
    // ========================================================================
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam int NUM_SPACES = 4;

    typedef enum logic [1:0] {
        cumf_secure,
        cumf_nonsecure,
        cumf_root,
        cumf_realm
    } cumf_space_e;

endpackage

// ==== cumf_view_if.sv ====
`timescale 1ns/1ps
interface cumf_view_if #(
    parameter int RIS_W = 4
);
    logic [RIS_W-1:0] resource_instance_selector;
    logic [31:0] feat;

    modport src (
        input resource_instance_selector,
        output feat
    );
    modport user (
        output resource_instance_selector,
        input feat
    );
endinterface

// ==== cumf_space_view.sv ====
`timescale 1ns/1ps
module cumf_space_view #(
    parameter int NINST = 2,
    parameter int RIS_W = 4,
    parameter bit INSTANCE_SELECTOR_PRESENT = 1'b1,
    parameter bit EXT_VER = 1'b1,
    parameter logic [NINST*32-1:0] TABLE = {NINST{32'hef00_0008}}
) (
    cumf_view_if.src view // Selected instance in, feature word out.
);

    // ========================================================================
    // Feature word for the selected instance
    // ========================================================================
    // Version-gated fields are masked here so a wrong table can never leak
    // a feature that the implemented version does not define.
    localparam logic [31:0] LIVE_MASK = ~cumf_pkg::RESERVED_MASK &
        (EXT_VER ? 32'hffff_ffff : ~cumf_pkg::VERSION_MASK);

    logic [RIS_W-1:0] idx;

    always_comb begin
        idx = INSTANCE_SELECTOR_PRESENT ? view.resource_instance_selector : '0;
        view.feat = 32'h0000_0000;
        if (int'(idx) < NINST) begin
            view.feat = TABLE[int'(idx)*32 +: 32] & LIVE_MASK;
        end
    end

endmodule

// ==== cumf_top.sv ====
`timescale 1ns/1ps
module cumf_top #(
    parameter bit HAS_PART = 1'b1,
    parameter bit HAS_MONITORS = 1'b1,
    parameter bit HAS_USAGE_MON = 1'b1,
    parameter bit EXT_VER = 1'b1,
    parameter bit INSTANCE_SELECTOR_PRESENT = 1'b1,
    parameter bit HAS_REALM_MGMT = 1'b1,
    parameter int NINST = 2,
    parameter int RIS_W = 4,
    parameter logic [cumf_pkg::NUM_SPACES*NINST*32-1:0] FEAT_TABLE =
        {(cumf_pkg::NUM_SPACES*NINST){32'hef00_0008}}
) (
    input logic clk_sys, // System clock.
    input logic rst_n, // Asynchronous reset, active low.
    input logic req, // Access request, one cycle.
    input logic wr, // Access is a write.
    input logic [1:0] space, // Security space of the page.
    input logic [cumf_pkg::ADDR_W-1:0] addr, // Byte offset in page.
    input logic [cumf_pkg::NUM_SPACES-1:0][RIS_W-1:0] part_sel_ris, // Sel.
    output logic ack, // Access answered, one cycle.
    output logic [31:0] rdata // Read data, held until next answer.
);

    // ========================================================================
    // Presence of each register
    // ========================================================================
    // The feature register needs partitioning, monitors and the usage
    // monitor type together; any one missing leaves the offset empty.
    localparam bit FEAT_LIVE = HAS_PART && HAS_MONITORS && HAS_USAGE_MON;
    localparam bit MAIN_LIVE = HAS_PART;
    localparam bit MAIN_WIDE = HAS_PART && EXT_VER;

    logic [cumf_pkg::NUM_SPACES-1:0] space_open;
    logic [31:0] feat_v [cumf_pkg::NUM_SPACES];
    logic [31:0] main_lo;
    logic [31:0] main_hi;

    // Root and realm pages exist only with realm management; without it
    // they read as zero like any empty offset.
    always_comb begin
        space_open = '0;
        for (int s = 0; s < cumf_pkg::NUM_SPACES; s++) begin
            space_open[s] = (s < 2) || HAS_REALM_MGMT;
        end
    end

    // ========================================================================
    // One feature copy per security space
    // ========================================================================
    genvar gs;
    generate
        for (gs = 0; gs < cumf_pkg::NUM_SPACES; gs++) begin : g_space
            cumf_view_if #(.RIS_W(RIS_W)) vif ();

            // Only the partition selector steers the copy; the monitor
            // selection register's instance field is never routed here.
            assign vif.resource_instance_selector = part_sel_ris[gs];

            cumf_space_view #(
                .NINST(NINST),
                .RIS_W(RIS_W),
                .INSTANCE_SELECTOR_PRESENT(INSTANCE_SELECTOR_PRESENT),
                .EXT_VER(EXT_VER),
                .TABLE(FEAT_TABLE[gs*NINST*32 +: NINST*32])
            ) u_view (
                .view(vif.src)
            );

            assign feat_v[gs] = vif.feat;
        end
    endgenerate

    // ========================================================================
    // Main identification register
    // ========================================================================
    always_comb begin
        main_lo = 32'h0000_0000;
        main_hi = 32'h0000_0000;
        main_lo[cumf_pkg::MAIN_MONITORS_BIT] = HAS_MONITORS;
        main_lo[cumf_pkg::MAIN_EXT_BIT] = EXT_VER;
        if (MAIN_WIDE) begin
            main_hi[cumf_pkg::MAIN_HI_SELECTOR_BIT] = INSTANCE_SELECTOR_PRESENT;
        end
    end

    // ========================================================================
    // Read port
    // ========================================================================
    logic next_ack;
    logic [31:0] next_rdata;

    always_comb begin
        next_ack = req;
        next_rdata = cumf_pkg::RDATA_RST;
        // Writes are answered with zero data and change nothing.
        if (req && !wr && space_open[space]) begin
            if (addr == cumf_pkg::FEAT_OFFSET) begin
                if (FEAT_LIVE) begin
                    next_rdata = feat_v[space];
                end
            end else if (addr == cumf_pkg::MAIN_LO_OFFSET) begin
                if (MAIN_LIVE) begin
                    next_rdata = main_lo;
                end
            end else if (addr == cumf_pkg::MAIN_HI_OFFSET) begin
                if (MAIN_WIDE) begin
                    next_rdata = main_hi;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            rdata <= cumf_pkg::RDATA_RST;
        end else begin
            ack <= next_ack;
            if (next_ack) begin
                rdata <= next_rdata;
            end
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    logic [RIS_W-1:0] cur_ris;
    logic [15:0] exp_count;
    int unsigned exp_idx;
    logic feat_rd;
    logic main_hi_rd;
    logic main_lo_rd;

    always_comb begin
        cur_ris = INSTANCE_SELECTOR_PRESENT ? part_sel_ris[space] : '0;
        exp_idx = 32'(space) * 32'(NINST) + 32'(cur_ris);
        exp_count = 16'h0000;
        if (FEAT_LIVE && space_open[space] && int'(cur_ris) < NINST) begin
            exp_count = FEAT_TABLE[exp_idx*32 +: 16];
        end
        feat_rd = req && !wr && addr == cumf_pkg::FEAT_OFFSET;
        main_lo_rd = req && !wr && addr == cumf_pkg::MAIN_LO_OFFSET;
        main_hi_rd = req && !wr && addr == cumf_pkg::MAIN_HI_OFFSET;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_ack_follows_req:
    assert property (req |=> ack ##1 (ack == $past(req)))
    else $error("answer missing one cycle after request");

    chk_absent_feature_zero:
    assert property (!FEAT_LIVE && feat_rd |=> rdata == 32'h0000_0000)
    else $error("absent feature register read nonzero");

    chk_reserved_bits_zero:
    assert property (feat_rd |=>
        (rdata & cumf_pkg::RESERVED_MASK) == 32'h0000_0000)
    else $error("reserved feature bits read nonzero");

    chk_version_bits_gated:
    assert property (!EXT_VER && feat_rd |=>
        (rdata & cumf_pkg::VERSION_MASK) == 32'h0000_0000)
    else $error("version feature bits set without extension");

    chk_count_field:
    assert property (feat_rd |=> rdata[15:0] == $past(exp_count))
    else $error("monitor count differs from configured value");

    chk_write_ignored:
    assert property (req && wr |=> ack && rdata == 32'h0000_0000)
    else $error("write answered with data");

    chk_main_narrow:
    assert property (!MAIN_WIDE && main_hi_rd |=> rdata == 32'h0000_0000)
    else $error("upper main word visible without extension");

    chk_main_selector_bit:
    assert property (MAIN_WIDE && main_hi_rd && space_open[space] |=>
        rdata[cumf_pkg::MAIN_HI_SELECTOR_BIT] == INSTANCE_SELECTOR_PRESENT)
    else $error("selector presence bit wrong");

    chk_main_monitor_bit:
    assert property (MAIN_LIVE && main_lo_rd && space_open[space] |=>
        rdata[cumf_pkg::MAIN_MONITORS_BIT] == HAS_MONITORS)
    else $error("monitor presence bit wrong");

    chk_closed_space_zero:
    assert property (req && !space_open[space] |=> rdata == 32'h0000_0000)
    else $error("closed page read nonzero");

    chk_rdata_held:
    assert property (!ack ##1 !ack |-> $stable(rdata))
    else $error("read data moved without an answer");

    cov_feature_read:
    cover property (feat_rd ##1 ack && rdata != 32'h0000_0000);

    cov_realm_read:
    cover property (feat_rd && space == 2'(cumf_pkg::cumf_realm) ##1 ack);

    cov_back_to_back:
    cover property (feat_rd ##1 feat_rd ##1 ack);

    cov_write_attempt:
    cover property (req && wr ##1 ack);

endmodule

// ==== cumf_tb.sv ====
`timescale 1ns/1ps
module testbench;
    localparam int NI = 2;
    localparam int RW = 4;
    // Every word sets reserved bits so that masking faults show up.
    localparam logic [cumf_pkg::NUM_SPACES*NI*32-1:0] TAB = {
        32'h1fff_0008, 32'h2eff_0107, 32'h3dff_0206, 32'h4cff_0305,
        32'h5bff_0404, 32'h6aff_0503, 32'h79ff_0602, 32'h88ff_0701};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [1:0] space = 2'h0;
    logic [cumf_pkg::ADDR_W-1:0] addr = 12'h000;
    logic [cumf_pkg::NUM_SPACES-1:0][RW-1:0] part_sel_ris = '0;
    wire [3:0] ack;
    wire [31:0] rdata [4];
    logic [31:0] got [4];
    int miscompares = 0;
    int compares = 0;

    // ======================================================================
    // Full device, no partitioning, base version, no root or realm pages
    // ======================================================================
    cumf_top #(.NINST(NI), .RIS_W(RW), .FEAT_TABLE(TAB)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .wr(wr),
        .space(space), .addr(addr), .part_sel_ris(part_sel_ris),
        .ack(ack[0]), .rdata(rdata[0]));
    cumf_top #(.HAS_PART(1'b0), .NINST(NI), .RIS_W(RW), .FEAT_TABLE(TAB))
        dut_u_nopart (
        .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .wr(wr),
        .space(space), .addr(addr), .part_sel_ris(part_sel_ris),
        .ack(ack[1]), .rdata(rdata[1]));
    cumf_top #(.EXT_VER(1'b0), .INSTANCE_SELECTOR_PRESENT(1'b0), .NINST(NI), .RIS_W(RW),
        .FEAT_TABLE(TAB)) dut_u_base (
        .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .wr(wr),
        .space(space), .addr(addr), .part_sel_ris(part_sel_ris),
        .ack(ack[2]), .rdata(rdata[2]));
    cumf_top #(.HAS_REALM_MGMT(1'b0), .NINST(NI), .RIS_W(RW),
        .FEAT_TABLE(TAB)) dut_u_closed (
        .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .wr(wr),
        .space(space), .addr(addr), .part_sel_ris(part_sel_ris),
        .ack(ack[3]), .rdata(rdata[3]));

    always #2 clk_sys = ~clk_sys;

    // ======================================================================
    // Comparisons, accesses and closing
    // ======================================================================
    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp,
                            input logic seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // The answer is sampled two edges after launch: one edge takes it.
    task automatic access(input logic w, input logic [1:0] s,
                          input logic [cumf_pkg::ADDR_W-1:0] a);
        @(posedge clk_sys);
        req <= 1'b1;
        wr <= w;
        space <= s;
        addr <= a;
        @(posedge clk_sys);
        req <= 1'b0;
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            got[k] = rdata[k];
            chk_flag("ack", 1'b1, ack[k]);
        end
    endtask

    function automatic logic [31:0] exp_feat(input int k, input bit ext);
        logic [31:0] m;
        m = ~cumf_pkg::RESERVED_MASK;
        if (!ext) m = m & ~cumf_pkg::VERSION_MASK;
        return TAB[k*32 +: 32] & m;
    endfunction

    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        chk_word("rdata in reset", 32'h0000_0000, rdata[0]);
        chk_flag("ack in reset", 1'b0, ack[0]);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        $display("test reset done");
        // Other spaces hold the opposite instance, so a wrong pick shows.
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < NI; i++) begin
                for (int q = 0; q < 4; q++)
                    part_sel_ris[q] <= RW'((q == s) ? i : 1 - i);
                access(1'b0, 2'(s), cumf_pkg::FEAT_OFFSET);
                chk_word("feat", exp_feat(s*NI+i, 1), got[0]);
                chk_word("feat nopart", 32'h0, got[1]);
                chk_word("feat base", exp_feat(s*NI, 0), got[2]);
                chk_word("feat closed", (s < 2) ? exp_feat(s*NI+i, 1)
                    : 32'h0, got[3]);
            end
        end
        $display("test feature pages done");
        part_sel_ris <= {4{4'h2}};
        access(1'b0, 2'h1, cumf_pkg::FEAT_OFFSET);
        chk_word("feat bad inst", 32'h0, got[0]);
        chk_word("feat base inst", exp_feat(NI, 0), got[2]);
        part_sel_ris <= '0;
        access(1'b1, 2'h0, cumf_pkg::FEAT_OFFSET);
        chk_word("write answer", 32'h0, got[0]);
        access(1'b0, 2'h0, cumf_pkg::FEAT_OFFSET);
        chk_word("feat after write", exp_feat(0, 1), got[0]);
        $display("test write ignored done");
        access(1'b0, 2'h3, cumf_pkg::MAIN_LO_OFFSET);
        chk_word("main low", 32'h5000_0000, got[0]);
        chk_word("main low nopart", 32'h0, got[1]);
        chk_word("main low base", 32'h4000_0000, got[2]);
        chk_word("main low closed", 32'h0, got[3]);
        access(1'b0, 2'h3, cumf_pkg::MAIN_HI_OFFSET);
        chk_word("main high", 32'h0000_0001, got[0]);
        chk_word("main high base", 32'h0, got[2]);
        access(1'b0, 2'h2, 12'h08c);
        chk_word("unmapped", 32'h0, got[0]);
        $display("test main register done");
        @(posedge clk_sys);
        req <= 1'b1;
        wr <= 1'b0;
        space <= 2'h2;
        addr <= cumf_pkg::FEAT_OFFSET;
        @(posedge clk_sys);
        addr <= cumf_pkg::MAIN_LO_OFFSET;
        @(posedge clk_sys);
        req <= 1'b0;
        chk_word("b2b first", exp_feat(2*NI, 1), rdata[0]);
        @(posedge clk_sys);
        chk_flag("b2b ack", 1'b1, ack[0]);
        chk_word("b2b second", 32'h5000_0000, rdata[0]);
        @(posedge clk_sys);
        chk_flag("ack drop", 1'b0, ack[0]);
        chk_word("rdata held", 32'h5000_0000, rdata[0]);
        $display("test back to back done");
        end_of_test;
    end
endmodule
